//--- src/ptr_ext_pkg.sv
// Purpose: Shared constants for the dual data pointer and extended address block
// Assumes: 8-bit special function register space, 24-bit external data address
// Notes: Offsets are the register addresses seen on the register port
package ptr_ext_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_SELECT = 8'h86;
  localparam logic [7:0] ADDR_PTR0_EXT = 8'h93;
  localparam logic [7:0] ADDR_PTR1_EXT = 8'h95;
  localparam logic [7:0] ADDR_INDIRECT_EXT = 8'hea;

  // ****************************************
  // Select register fields
  // ****************************************
  localparam int SEL_BIT = 0;
  localparam int TOGGLE_BIT = 5;
  localparam int DIR0_BIT = 6;
  localparam int DIR1_BIT = 7;
  localparam logic [7:0] SELECT_MASK = 8'he1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

//--- src/addr_form_if.sv
// Purpose: Carries pointer state to the address former and the address back
// Assumes: Single clock domain
// Notes: Owner drives pointer state, former drives the formed address
`timescale 1ns/1ns
`default_nettype none
interface addr_form_if;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic sel;
  logic [7:0] ext0;
  logic [7:0] ext1;
  logic [7:0] ext_ind;
  logic [7:0] port_two;
  logic [7:0] ri_low;
  logic use_ptr;
  logic use_ri;
  logic [23:0] addr;
  logic addr_valid;

  modport owner (
    output ptr0, ptr1, sel, ext0, ext1, ext_ind, port_two, ri_low, use_ptr, use_ri,
    input addr, addr_valid
  );
  modport former (
    input ptr0, ptr1, sel, ext0, ext1, ext_ind, port_two, ri_low, use_ptr, use_ri,
    output addr, addr_valid
  );
endinterface
`default_nettype wire

//--- src/ext_addr_former.sv
// Purpose: Forms the registered 24-bit external data address for a data move
// Assumes: Move strobes are single-cycle and come from logic on clk_sys
// Notes: Address holds until the next move strobe
`timescale 1ns/1ns
`default_nettype none
module ext_addr_former
  import ptr_ext_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Pointer state and address
  addr_form_if.former af
);

  // ****************************************
  // Address register
  // ****************************************
  logic [23:0] addr_q;
  logic valid_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= 24'h000000;
    end
    else if (ce && af.use_ptr)
    begin
      addr_q <= af.sel ? {af.ext1, af.ptr1} : {af.ext0, af.ptr0};
    end
    else if (ce && af.use_ri)
    begin
      addr_q <= {af.ext_ind, af.port_two, af.ri_low};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_q <= 1'b0;
    end
    else if (ce)
    begin
      valid_q <= af.use_ptr | af.use_ri;
    end
  end

  assign af.addr = addr_q;
  assign af.addr_valid = valid_q;

  // ****************************************
  // Checks
  // ****************************************
  a_ptr_move_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && af.use_ptr |=> af.addr_valid &&
      af.addr == ($past(af.sel) ? {$past(af.ext1), $past(af.ptr1)}
                                : {$past(af.ext0), $past(af.ptr0)}))
    else $error("pointer move address wrong");
  a_ri_move_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && af.use_ri && !af.use_ptr |=> af.addr[23:16] == $past(af.ext_ind))
    else $error("indirect move upper byte wrong");
  a_ri_move_mid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && af.use_ri && !af.use_ptr |=> af.addr[15:8] == $past(af.port_two) &&
      af.addr[7:0] == $past(af.ri_low))
    else $error("indirect move middle byte wrong");

endmodule // ext_addr_former
`default_nettype wire

//--- src/dual_data_pointer_ext_addr.sv
// Purpose: Dual data pointers with extension bytes forming 24-bit data addresses
// Assumes: Register port and instruction strobes come from the core on clk_sys
// Notes: A register write in the same cycle as an instruction update wins
//
// Summary of operation
// - Three 8-bit extension bytes supply address bits 23:16
// - Reset clears both pointer extensions and indirect extension
// - Pointer moves take upper byte from paired extension
// - Indirect moves take upper byte from indirect extension
// - Indirect moves take middle byte from port two
// - Select bit zero chooses pointer zero or one
`timescale 1ns/1ns
`default_nettype none
module dual_data_pointer_ext_addr
  import ptr_ext_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  // Instruction strobes from the core
  input wire logic ptr_instr,
  input wire logic inc_ptr,
  input wire logic movx_ptr,
  input wire logic movx_ri,
  input wire logic [7:0] ri_value,
  input wire logic [7:0] port_two_latch,
  // Formed address and active pointer
  output logic [23:0] ext_addr,
  output logic ext_addr_valid,
  output logic [15:0] active_ptr
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic down);
    step_ptr = down ? 16'(p - 16'h0001) : 16'(p + 16'h0001);
  endfunction

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = ce && sfr_wr && (sfr_addr == a);
  endfunction

  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [7:0] select_q;
  logic [7:0] ext0_q;
  logic [7:0] ext1_q;
  logic [7:0] ext_ind_q;
  logic [7:0] rdata_q;
  logic sel;
  logic toggle_en;
  addr_form_if af ();

  assign sel = select_q[SEL_BIT];
  assign toggle_en = select_q[TOGGLE_BIT];
  assign active_ptr = sel ? ptr1_q : ptr0_q;

  // ****************************************
  // Data pointers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr0_q <= PTR_RESET;
    end
    else if (wr_at(ADDR_PTR0_LOW))
    begin
      ptr0_q[7:0] <= sfr_wdata;
    end
    else if (wr_at(ADDR_PTR0_HIGH))
    begin
      ptr0_q[15:8] <= sfr_wdata;
    end
    else if (ce && inc_ptr && !sel)
    begin
      ptr0_q <= step_ptr(ptr0_q, select_q[DIR0_BIT]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr1_q <= PTR_RESET;
    end
    else if (wr_at(ADDR_PTR1_LOW))
    begin
      ptr1_q[7:0] <= sfr_wdata;
    end
    else if (wr_at(ADDR_PTR1_HIGH))
    begin
      ptr1_q[15:8] <= sfr_wdata;
    end
    else if (ce && inc_ptr && sel)
    begin
      ptr1_q <= step_ptr(ptr1_q, select_q[DIR1_BIT]);
    end
  end

  // ****************************************
  // Select register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      select_q <= SELECT_RESET;
    end
    else if (wr_at(ADDR_SELECT))
    begin
      select_q <= sfr_wdata & SELECT_MASK;
    end
    else if (ce && toggle_en && (ptr_instr || inc_ptr || movx_ptr))
    begin
      select_q[SEL_BIT] <= !sel;
    end
  end

  // ****************************************
  // Extension registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext0_q <= EXT_RESET;
      ext1_q <= EXT_RESET;
      ext_ind_q <= EXT_RESET;
    end
    else
    begin
      if (wr_at(ADDR_PTR0_EXT))
      begin
        ext0_q <= sfr_wdata;
      end
      if (wr_at(ADDR_PTR1_EXT))
      begin
        ext1_q <= sfr_wdata;
      end
      if (wr_at(ADDR_INDIRECT_EXT))
      begin
        ext_ind_q <= sfr_wdata;
      end
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_comb
  begin
    case (sfr_addr)
      ADDR_PTR0_LOW, ADDR_PTR0_HIGH, ADDR_PTR1_LOW, ADDR_PTR1_HIGH, ADDR_SELECT,
      ADDR_PTR0_EXT, ADDR_PTR1_EXT, ADDR_INDIRECT_EXT: sfr_hit = 1'b1;
      default: sfr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= UNMAPPED_READ;
    end
    else if (ce && sfr_rd)
    begin
      case (sfr_addr)
        ADDR_PTR0_LOW: rdata_q <= ptr0_q[7:0];
        ADDR_PTR0_HIGH: rdata_q <= ptr0_q[15:8];
        ADDR_PTR1_LOW: rdata_q <= ptr1_q[7:0];
        ADDR_PTR1_HIGH: rdata_q <= ptr1_q[15:8];
        ADDR_SELECT: rdata_q <= select_q;
        ADDR_PTR0_EXT: rdata_q <= ext0_q;
        ADDR_PTR1_EXT: rdata_q <= ext1_q;
        ADDR_INDIRECT_EXT: rdata_q <= ext_ind_q;
        default: rdata_q <= UNMAPPED_READ;
      endcase
    end
  end

  assign sfr_rdata = rdata_q;

  // ****************************************
  // Address forming
  // ****************************************
  assign af.ptr0 = ptr0_q;
  assign af.ptr1 = ptr1_q;
  assign af.sel = sel;
  assign af.ext0 = ext0_q;
  assign af.ext1 = ext1_q;
  assign af.ext_ind = ext_ind_q;
  assign af.port_two = port_two_latch;
  assign af.ri_low = ri_value;
  assign af.use_ptr = movx_ptr;
  assign af.use_ri = movx_ri;

  ext_addr_former u_former (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .af(af.former)
  );

  assign ext_addr = af.addr;
  assign ext_addr_valid = af.addr_valid;

  // ****************************************
  // Checks
  // ****************************************
  a_ext_reset_zero: assert property (@(posedge clk_sys)
    !rst_n |-> ext0_q == EXT_RESET && ext1_q == EXT_RESET && ext_ind_q == EXT_RESET)
    else $error("extension not cleared by reset");
  a_ext_write_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_at(ADDR_PTR1_EXT) |=> ext1_q == $past(sfr_wdata) ##1 (ext1_q == $past(ext1_q) ||
      $past(wr_at(ADDR_PTR1_EXT))))
    else $error("extension write not held");
  a_active_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_at(sel ? ADDR_PTR1_LOW : ADDR_PTR0_LOW) && !(ptr_instr || inc_ptr || movx_ptr)
      |=> active_ptr[7:0] == $past(sfr_wdata))
    else $error("active pointer mismatch");
  a_select_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && toggle_en && (ptr_instr || movx_ptr) && !wr_at(ADDR_SELECT)
      |=> sel != $past(sel))
    else $error("select did not toggle");
  a_select_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !toggle_en && !wr_at(ADDR_SELECT) |=> $stable(sel))
    else $error("select changed without toggle");
  a_inc_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && inc_ptr && !sel && !select_q[DIR0_BIT] && !sfr_wr
      |=> ptr0_q == 16'($past(ptr0_q) + 16'h0001))
    else $error("pointer zero increment wrong");
  a_dec_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && inc_ptr && sel && select_q[DIR1_BIT] && !sfr_wr
      |=> ptr1_q == 16'($past(ptr1_q) - 16'h0001))
    else $error("pointer one decrement wrong");

  c_toggle_move: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ce && toggle_en && movx_ptr ##1 ce && movx_ptr);
  c_ri_move: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ce && movx_ri && ext_ind_q != EXT_RESET);
  c_dec_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ce && inc_ptr && !sel && select_q[DIR0_BIT] && ptr0_q == PTR_RESET);

endmodule // dual_data_pointer_ext_addr
`default_nettype wire

//--- dv/core_model.sv
// Purpose: Core model that turns a command code into instruction strobes
// Assumes: Bench holds op for one clk_sys cycle per instruction
// Notes: Register and port lines carry inverted junk outside indirect moves
`timescale 1ns/1ns
`default_nettype none
module core_model
(
  // Command from the bench
  input wire logic [2:0] op,
  input wire logic [7:0] ri_in,
  input wire logic [7:0] p2_in,
  // Strobes to the block
  output logic ptr_instr,
  output logic inc_ptr,
  output logic movx_ptr,
  output logic movx_ri,
  output logic [7:0] ri_value,
  output logic [7:0] port_two_latch
);
  assign ptr_instr = (op == 3'h1);
  assign inc_ptr = (op == 3'h2);
  assign movx_ptr = (op == 3'h3);
  assign movx_ri = (op == 3'h4);
  // Lines are only meaningful with an indirect move
  assign ri_value = movx_ri ? ri_in : ~ri_in;
  assign port_two_latch = movx_ri ? p2_in : ~p2_in;
endmodule // core_model
`default_nettype wire

//--- dv/dual_data_pointer_ext_addr_tb.sv
// Purpose: Self-checking bench for the dual pointer address block
// Assumes: Inputs change on the falling edge of clk_sys
// Notes: One idle cycle separates register and instruction requests
`timescale 1ns/1ns
`default_nettype none
module dual_data_pointer_ext_addr_tb;
  import ptr_ext_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [2:0] op = 3'h0;
  logic [7:0] ri_in = 8'h21;
  logic [7:0] p2_in = 8'h44;
  logic sfr_hit, ptr_instr, inc_ptr, movx_ptr, movx_ri, ext_addr_valid;
  logic [7:0] sfr_rdata, ri_value, port_two_latch;
  logic [23:0] ext_addr;
  logic [15:0] active_ptr;
  logic [7:0] regs [9] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h95, 8'hea, 8'h90};
  logic [7:0] vals [9] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'hff, 8'h5a, 8'hc3, 8'h7e, 8'h77};
  logic [7:0] rexp [9] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'he1, 8'h5a, 8'hc3, 8'h7e, 8'h00};
  logic [7:0] sels [8] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h01, 8'h41, 8'h81, 8'hc1};
  logic [15:0] pexp;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 clk_sys = ~clk_sys;

  dual_data_pointer_ext_addr i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata), .ptr_instr(ptr_instr), .inc_ptr(inc_ptr),
    .movx_ptr(movx_ptr), .movx_ri(movx_ri), .ri_value(ri_value),
    .port_two_latch(port_two_latch), .ext_addr(ext_addr), .ext_addr_valid(ext_addr_valid),
    .active_ptr(active_ptr));

  core_model i_core (.op(op), .ri_in(ri_in), .p2_in(p2_in), .ptr_instr(ptr_instr),
    .inc_ptr(inc_ptr), .movx_ptr(movx_ptr), .movx_ri(movx_ri), .ri_value(ri_value),
    .port_two_latch(port_two_latch));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk(24'(sfr_rdata), 24'(exp));
  endtask

  task automatic do_op(input logic [2:0] o);
    @(negedge clk_sys);
    op = o;
    @(negedge clk_sys);
    op = 3'h0;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      end_sim();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    // Clean reset edge before the first clock edge
    #10 rst_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    chk(24'(sfr_hit), 24'h0);
    $display("test reset done");
    foreach (regs[i]) wr(regs[i], vals[i]);
    foreach (regs[i]) rd(regs[i], rexp[i]);
    ce = 1'b0;
    wr(ADDR_PTR0_EXT, 8'h00);
    ce = 1'b1;
    rd(ADDR_PTR0_EXT, 8'h5a);
    chk(24'(sfr_hit), 24'h1);
    $display("test registers done");
    wr(ADDR_SELECT, 8'h00);
    do_op(3'h3);
    chk(ext_addr, 24'h5a1234);
    chk(24'(ext_addr_valid), 24'h1);
    chk(24'(active_ptr), 24'h1234);
    wr(ADDR_SELECT, 8'h01);
    do_op(3'h3);
    chk(ext_addr, 24'hc3abcd);
    chk(24'(active_ptr), 24'habcd);
    do_op(3'h4);
    chk(ext_addr, 24'h7e4421);
    @(negedge clk_sys);
    chk(24'(ext_addr_valid), 24'h0);
    $display("test moves done");
    wr(ADDR_SELECT, 8'h20);
    @(negedge clk_sys);
    op = 3'h3;
    @(negedge clk_sys);
    chk(ext_addr, 24'h5a1234);
    chk(24'(active_ptr), 24'habcd);
    @(negedge clk_sys);
    op = 3'h0;
    chk(ext_addr, 24'hc3abcd);
    do_op(3'h1);
    chk(24'(active_ptr), 24'habcd);
    wr(ADDR_SELECT, 8'h00);
    do_op(3'h1);
    chk(24'(active_ptr), 24'h1234);
    $display("test toggle done");
    foreach (sels[i])
    begin
      wr(ADDR_PTR0_LOW, 8'h00);
      wr(ADDR_PTR0_HIGH, 8'h10);
      wr(ADDR_PTR1_LOW, 8'h00);
      wr(ADDR_PTR1_HIGH, 8'h10);
      wr(ADDR_SELECT, sels[i]);
      do_op(3'h2);
      pexp = sels[i][6 + sels[i][0]] ? 16'h0fff : 16'h1001;
      chk(24'(active_ptr), 24'(pexp));
    end
    wr(ADDR_SELECT, 8'h40);
    wr(ADDR_PTR0_LOW, 8'h00);
    wr(ADDR_PTR0_HIGH, 8'h00);
    do_op(3'h2);
    chk(24'(active_ptr), 24'hffff);
    wr(ADDR_SELECT, 8'h00);
    do_op(3'h2);
    chk(24'(active_ptr), 24'h0000);
    $display("test step done");
    // Mid-run reset with non-zero extension bytes and a formed address
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    chk(ext_addr, 24'h000000);
    chk(24'(ext_addr_valid), 24'h0);
    rd(ADDR_PTR0_EXT, 8'h00);
    rd(ADDR_PTR1_EXT, 8'h00);
    rd(ADDR_INDIRECT_EXT, 8'h00);
    $display("test second reset done");
    end_sim();
  end
endmodule // dual_data_pointer_ext_addr_tb
`default_nettype wire
